// ---- hw/sps_consts.svh ----
// constants of the stepper phase sequencer: offsets, fields, resets, timing
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define SPS_CLK_MHZ         50
`define SPS_BOOST_ON_US     260
`define SPS_BOOST_CYCLES    (`SPS_BOOST_ON_US * `SPS_CLK_MHZ)
`define SPS_PWRUP_HOLD_NS   2000
`define SPS_PWRUP_CYCLES    ((`SPS_PWRUP_HOLD_NS * `SPS_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SPS_OFS_CTRL        8'h00
`define SPS_OFS_BOOST_TC    8'h04
`define SPS_OFS_STATUS      8'h08
`define SPS_OFS_STEP_COUNT  8'h0c

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define SPS_CTRL_SOFT_KILL  0
`define SPS_CTRL_BOOST_EN   1
`define SPS_CTRL_RESET      2'h2
`define SPS_ST_PHASE_LSB    0
`define SPS_ST_DRIVE_LSB    4
`define SPS_ST_ZERO_LSB     8
`define SPS_ST_BOOST_LSB    10
`define SPS_ST_KILL         12
`define SPS_ST_READY        13
`define SPS_PHASE_RESET     3'h1

`endif

// ---- hw/sps_pkg.sv ----
// types shared by the stepper phase sequencer
package sps_pkg;

  // four winding drives, high means the transistor sinks current
  typedef struct packed {
    logic a1;
    logic a2;
    logic b1;
    logic b2;
  } sps_drive_t;

  // per-phase pair of flags (zero current, boost)
  typedef struct packed {
    logic a;
    logic b;
  } sps_pair_t;

  // controls captured at the falling step edge
  typedef struct packed {
    logic fwd;
    logic half;
  } sps_step_ctl_t;

  // power-up sequencing
  typedef enum logic [0:0] {
    SPS_HOLD,
    SPS_RUN
  } sps_pwr_state_t;

endpackage

// ---- hw/sps_phase_sequencer.sv ----
// stepper phase sequencer: step logic, phase drives, zero flags, bilevel timers
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "sps_consts.svh"

// What this block does
// R01 - one phase step per falling step strobe edge, never on rising edges
// R02 - in half-step mode two falling edges make one full step
// R03 - half_step_select low means half-step, high means full-step
// R04 - rotation_sense picks forward or backward walk through the states
// R05 - rotation_sense and half_step_select are taken at the falling step edge
// R06 - controller never changes direction or mode coincident with the step edge
// R07 - output_kill high forces all four phase drives off
// R08 - an unconnected logic input reads as high
// R09 - after each phase change that phase's boost output is asserted
// R10 - boost stays on for a fixed on-time, then drops
// R11 - one zero-current flag per phase at half-step positions
// R12 - each change of a phase's drive triggers that phase's boost timer
// R13 - reset sets phase state to position 1 and holds outputs inhibited until ready
// R14 - zero flags tell outside logic the phase current is switched off
// R15 - eight half-step states; full-step uses both-energised states only
// R16 - boost timer is a restartable counter with programmable terminal count
module sps_phase_sequencer
  import sps_pkg::*;
#(
  parameter int unsigned BOOST_CYCLES = `SPS_BOOST_CYCLES, // default boost on-time
  parameter int unsigned PWRUP_CYCLES = `SPS_PWRUP_CYCLES, // output hold after reset
  parameter int unsigned TC_W         = 16,                // boost counter width
  parameter int unsigned ADDR_W       = 8                  // register address width
) (
  input  wire logic              clock_in,             // 50 MHz system clock
  input  wire logic              resetn_in,            // synchronous reset, active low
  input  wire logic              step_strobe_in,       // step strobe, falling edge steps
  input  wire logic              rotation_sense_in,    // high forward, low backward
  input  wire logic              half_step_select_in,  // low half-step, high full-step
  input  wire logic              output_kill_in,       // high turns all phases off
  input  wire logic [ADDR_W-1:0] reg_addr_in,          // register byte address
  input  wire logic [31:0]       reg_wdata_in,         // register write data
  input  wire logic              reg_wr_in,            // write strobe
  input  wire logic              reg_rd_in,            // read strobe
  output logic      [31:0]       reg_rdata_out,        // read data, cycle after strobe
  output logic                   winding_a_drive_1_out, // phase a, output 1
  output logic                   winding_a_drive_2_out, // phase a, output 2
  output logic                   winding_b_drive_1_out, // phase b, output 1
  output logic                   winding_b_drive_2_out, // phase b, output 2
  output logic                   zero_current_a_out,   // phase a carries no current
  output logic                   zero_current_b_out,   // phase b carries no current
  output logic                   boost_output_a_out,   // second level drive, phase a
  output logic                   boost_output_b_out    // second level drive, phase b
);

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------

  // drive pattern of a half-step position; odd positions energise both phases
  function automatic sps_drive_t drive_of(input logic [2:0] s);
    sps_drive_t d;
    d    = '0;
    d.a1 = (s == 3'h7) || (s == 3'h0) || (s == 3'h1); // R15
    d.b1 = (s == 3'h1) || (s == 3'h2) || (s == 3'h3); // R15
    d.a2 = (s == 3'h3) || (s == 3'h4) || (s == 3'h5); // R15
    d.b2 = (s == 3'h5) || (s == 3'h6) || (s == 3'h7); // R15
    return d;
  endfunction

  // zero-current positions of each phase
  function automatic sps_pair_t zero_of(input logic [2:0] s);
    sps_pair_t z;
    z   = '0;
    z.a = (s == 3'h2) || (s == 3'h6); // R11
    z.b = (s == 3'h0) || (s == 3'h4); // R11
    return z;
  endfunction

  // next position for one step with the captured direction and mode
  function automatic logic [2:0] next_pos(input logic [2:0] s, input sps_step_ctl_t c);
    logic [2:0] inc;
    inc = 3'h1;
    // full step from a both-energised state jumps two half positions;
    // from a half position it first lands on the nearest full position
    if (!c.half && s[0]) begin // R15
      inc = 3'h2;
    end
    if (c.fwd) begin // R04
      return 3'(s + inc);
    end else begin
      return 3'(s - inc);
    end
  endfunction

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  sps_pwr_state_t pwr_r, pwr_nxt;
  logic [TC_W-1:0] hold_cnt_r, hold_cnt_nxt;
  logic            strobe_prev_r, strobe_prev_nxt;
  logic [2:0]      phase_r, phase_nxt;
  logic [15:0]     step_cnt_r, step_cnt_nxt;
  logic [TC_W-1:0] boost_a_cnt_r, boost_a_cnt_nxt;
  logic [TC_W-1:0] boost_b_cnt_r, boost_b_cnt_nxt;
  logic            soft_kill_r, soft_kill_nxt;
  logic            boost_en_r, boost_en_nxt;
  logic [TC_W-1:0] boost_tc_r, boost_tc_nxt;
  logic [31:0]     rdata_r, rdata_nxt;
  sps_drive_t      drive_r, drive_nxt;
  sps_pair_t       zero_r, zero_nxt;
  sps_pair_t       boost_r, boost_nxt;

  logic            step_fall;
  sps_step_ctl_t   step_ctl;
  sps_drive_t      cur_drive;
  sps_drive_t      new_drive;
  logic            trig_a;
  logic            trig_b;
  logic            kill_any;
  logic            ready;

  // --------------------------------------------------------------------------
  // power-up hold
  // --------------------------------------------------------------------------

  // outputs stay inhibited for a short hold after reset release
  always_comb begin
    pwr_nxt      = pwr_r;
    hold_cnt_nxt = hold_cnt_r;
    case (pwr_r)
      SPS_HOLD: begin
        if (hold_cnt_r >= TC_W'(PWRUP_CYCLES - 1)) begin // R13
          pwr_nxt = SPS_RUN;
        end else begin
          hold_cnt_nxt = hold_cnt_r + 1'b1;
        end
      end
      SPS_RUN: begin
        pwr_nxt = SPS_RUN;
      end
      default: begin
        pwr_nxt = SPS_HOLD;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      pwr_r      <= SPS_HOLD; // R13
      hold_cnt_r <= '0;
    end else begin
      pwr_r      <= pwr_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  assign ready = (pwr_r == SPS_RUN);

  // --------------------------------------------------------------------------
  // step edge detection and phase state
  // --------------------------------------------------------------------------

  // a step is taken only on a high-to-low strobe change once running;
  // the previous strobe resets high, so a strobe held low at release reads as a fall that only the hold masks
  assign step_fall         = strobe_prev_r && !step_strobe_in && ready; // R01
  assign step_ctl.fwd      = rotation_sense_in;   // R05
  assign step_ctl.half     = !half_step_select_in; // R03 R05

  // phase position, strobe history and step count
  always_comb begin
    strobe_prev_nxt = step_strobe_in;
    phase_nxt       = phase_r;
    step_cnt_nxt    = step_cnt_r;
    if (step_fall) begin // R01 R02
      phase_nxt    = next_pos(phase_r, step_ctl);
      step_cnt_nxt = step_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      strobe_prev_r <= 1'b1; // R08
      phase_r       <= `SPS_PHASE_RESET; // R13
      step_cnt_r    <= '0;
    end else begin
      strobe_prev_r <= strobe_prev_nxt;
      phase_r       <= phase_nxt;
      step_cnt_r    <= step_cnt_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // bilevel timers
  // --------------------------------------------------------------------------

  // a phase triggers whenever the pair of drives belonging to it changes
  assign cur_drive = drive_of(phase_r);
  assign new_drive = drive_of(phase_nxt);
  assign trig_a    = step_fall
                     && ({cur_drive.a1, cur_drive.a2} != {new_drive.a1, new_drive.a2}); // R12
  assign trig_b    = step_fall
                     && ({cur_drive.b1, cur_drive.b2} != {new_drive.b1, new_drive.b2}); // R12

  // each counter reloads on a new trigger and counts down to zero
  always_comb begin
    boost_a_cnt_nxt = boost_a_cnt_r;
    boost_b_cnt_nxt = boost_b_cnt_r;
    if (trig_a && boost_en_r) begin // R09 R16
      boost_a_cnt_nxt = boost_tc_r;
    end else if (boost_a_cnt_r != '0) begin // R10
      boost_a_cnt_nxt = boost_a_cnt_r - 1'b1;
    end
    if (trig_b && boost_en_r) begin // R09 R16
      boost_b_cnt_nxt = boost_tc_r;
    end else if (boost_b_cnt_r != '0) begin // R10
      boost_b_cnt_nxt = boost_b_cnt_r - 1'b1;
    end
    // a kill drops any running on-time, so boost never resumes part-way after release
    if (kill_any) begin // R07
      boost_a_cnt_nxt = '0;
      boost_b_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      boost_a_cnt_r <= '0;
      boost_b_cnt_r <= '0;
    end else begin
      boost_a_cnt_r <= boost_a_cnt_nxt;
      boost_b_cnt_r <= boost_b_cnt_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // output stage
  // --------------------------------------------------------------------------

  // kill from the pin or from software; outputs held off until ready
  assign kill_any = output_kill_in || soft_kill_r || !ready;

  // registered drives follow the next phase, so they change with the step
  always_comb begin
    drive_nxt   = new_drive;
    zero_nxt    = zero_of(phase_nxt); // R11 R14
    boost_nxt.a = (boost_a_cnt_nxt != '0);
    boost_nxt.b = (boost_b_cnt_nxt != '0);
    if (kill_any) begin // R07 R13
      drive_nxt = '0;
      boost_nxt = '0;
    end
    if (!ready) begin // R13
      zero_nxt = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      drive_r <= '0; // R13
      zero_r  <= '0;
      boost_r <= '0;
    end else begin
      drive_r <= drive_nxt;
      zero_r  <= zero_nxt;
      boost_r <= boost_nxt;
    end
  end

  assign winding_a_drive_1_out = drive_r.a1;
  assign winding_a_drive_2_out = drive_r.a2;
  assign winding_b_drive_1_out = drive_r.b1;
  assign winding_b_drive_2_out = drive_r.b2;
  assign zero_current_a_out    = zero_r.a;
  assign zero_current_b_out    = zero_r.b;
  assign boost_output_a_out    = boost_r.a;
  assign boost_output_b_out    = boost_r.b;

  // --------------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------------

  // writes steer the soft kill, boost enable and boost on-time
  always_comb begin
    soft_kill_nxt = soft_kill_r;
    boost_en_nxt  = boost_en_r;
    boost_tc_nxt  = boost_tc_r;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `SPS_OFS_CTRL: begin
          soft_kill_nxt = reg_wdata_in[`SPS_CTRL_SOFT_KILL];
          boost_en_nxt  = reg_wdata_in[`SPS_CTRL_BOOST_EN];
        end
        `SPS_OFS_BOOST_TC: begin
          boost_tc_nxt = reg_wdata_in[TC_W-1:0]; // R16
        end
        default: begin
          boost_tc_nxt = boost_tc_r;
        end
      endcase
    end
  end

  // reads return data in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `SPS_OFS_CTRL: begin
          rdata_nxt[`SPS_CTRL_SOFT_KILL] = soft_kill_r;
          rdata_nxt[`SPS_CTRL_BOOST_EN]  = boost_en_r;
        end
        `SPS_OFS_BOOST_TC: begin
          rdata_nxt[TC_W-1:0] = boost_tc_r;
        end
        `SPS_OFS_STATUS: begin
          rdata_nxt[`SPS_ST_PHASE_LSB +: 3] = phase_r;
          rdata_nxt[`SPS_ST_DRIVE_LSB +: 4] = drive_r;
          rdata_nxt[`SPS_ST_ZERO_LSB +: 2]  = zero_r;
          rdata_nxt[`SPS_ST_BOOST_LSB +: 2] = boost_r;
          rdata_nxt[`SPS_ST_KILL]           = kill_any;
          rdata_nxt[`SPS_ST_READY]          = ready;
        end
        `SPS_OFS_STEP_COUNT: begin
          rdata_nxt[15:0] = step_cnt_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      soft_kill_r <= 1'b0;
      boost_en_r  <= 1'(`SPS_CTRL_RESET >> `SPS_CTRL_BOOST_EN);
      boost_tc_r  <= TC_W'(BOOST_CYCLES);
      rdata_r     <= '0;
    end else begin
      soft_kill_r <= soft_kill_nxt;
      boost_en_r  <= boost_en_nxt;
      boost_tc_r  <= boost_tc_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule

// ---- bench/sps_phase_sequencer_asserts.sv ----
// port checker of the stepper phase sequencer
`timescale 1ns/1ps
module sps_chk #(
  parameter int unsigned BOOST_CYCLES = 20, // boost on-time in cycles
  parameter int unsigned ADDR_W       = 8   // address width
) (
  input wire logic              clock_in,              // clock
  input wire logic              resetn_in,             // reset, active low
  input wire logic              step_strobe_in,        // step strobe
  input wire logic              output_kill_in,        // kill pin
  input wire logic [ADDR_W-1:0] reg_addr_in,           // address
  input wire logic              reg_wr_in,             // write strobe
  input wire logic              reg_rd_in,             // read strobe
  input wire logic [31:0]       reg_rdata_out,         // read data
  input wire logic              winding_a_drive_1_out, // drive a1
  input wire logic              winding_a_drive_2_out, // drive a2
  input wire logic              winding_b_drive_1_out, // drive b1
  input wire logic              winding_b_drive_2_out, // drive b2
  input wire logic              zero_current_a_out,    // zero flag a
  input wire logic              zero_current_b_out,    // zero flag b
  input wire logic              boost_output_a_out,    // boost a
  input wire logic              boost_output_b_out     // boost b
);
  logic [3:0]  drv, drv_q_r;
  logic [1:0]  zro, bst;
  logic        fall, strobe_q_r, wr_q_r, step_ok_r, step_ok_nxt;
  logic [15:0] cnt_a_r, cnt_a_nxt;
  // grouped outputs and the strobe fall seen at this edge
  assign drv  = {winding_a_drive_1_out, winding_a_drive_2_out,
                 winding_b_drive_1_out, winding_b_drive_2_out};
  assign zro  = {zero_current_a_out, zero_current_b_out};
  assign bst  = {boost_output_a_out, boost_output_b_out};
  assign fall = strobe_q_r & ~step_strobe_in;
  // accepted step flag and boost a run length, restarted on a new a drive
  always_comb begin
    step_ok_nxt = fall & (|drv) & ~output_kill_in & ~reg_wr_in & ~wr_q_r;
    cnt_a_nxt   = 16'h0000;
    if (bst[1] && drv[3:2] != drv_q_r[3:2] && drv[3:2] != 2'h0) begin
      cnt_a_nxt = 16'h0001;
    end else if (bst[1]) begin
      cnt_a_nxt = cnt_a_r + 16'h0001;
    end
  end
  // helper registers, strobe history starts high like the design's
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      strobe_q_r <= 1'b1;
      wr_q_r     <= 1'b0;
      step_ok_r  <= 1'b0;
      drv_q_r    <= 4'h0;
      cnt_a_r    <= 16'h0000;
    end else begin
      strobe_q_r <= step_strobe_in;
      wr_q_r     <= reg_wr_in;
      step_ok_r  <= step_ok_nxt;
      drv_q_r    <= drv;
      cnt_a_r    <= cnt_a_nxt;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  AST_RESET_OFF: assert property (disable iff (1'b0) !resetn_in |=>
    {drv, zro, bst} == 8'h00) else $error("outputs not off after reset");
  AST_HOLD_STILL: assert property (|drv && !fall && !output_kill_in && !reg_wr_in
    && !$past(reg_wr_in) |=> $stable(drv)) else $error("drives moved without a falling strobe");
  AST_STEP_MOVES: assert property (step_ok_nxt |=> !$stable(drv))
    else $error("falling strobe did not move the drives");
  AST_KILL_OFF: assert property (output_kill_in |=> drv == 4'h0 && bst == 2'h0)
    else $error("kill did not turn outputs off");
  AST_ONE_PER_PHASE: assert property (drv[3:2] != 2'h3 && drv[1:0] != 2'h3)
    else $error("both outputs of one phase on");
  AST_ZERO_FLAGS: assert property (|drv |-> zro == {drv[3:2] == 2'h0, drv[1:0] == 2'h0})
    else $error("zero flag does not match phase current");
  AST_BOOST_TRIG_A: assert property (step_ok_r && drv[3:2] != drv_q_r[3:2]
    && drv[3:2] != 2'h0 |-> bst[1]) else $error("phase a change without boost");
  AST_BOOST_TRIG_B: assert property (step_ok_r && drv[1:0] != drv_q_r[1:0]
    && drv[1:0] != 2'h0 |-> bst[0]) else $error("phase b change without boost");
  AST_BOOST_LEN: assert property (bst[1] |-> cnt_a_r < BOOST_CYCLES)
    else $error("boost a on too long");
  AST_BOOST_END: assert property ($fell(boost_output_a_out) && !$past(output_kill_in)
    && $past(resetn_in) |-> cnt_a_r == BOOST_CYCLES) else $error("boost a ended early");
  AST_RD_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside read cycle");
  AST_RD_UNMAPPED: assert property ($past(reg_rd_in) && $past(reg_addr_in) > 8'h0c
    |-> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
  // main scenarios reached
  COV_STEP: cover property (step_ok_r);
  COV_KILL: cover property (output_kill_in && fall);
  COV_BOOST_END: cover property ($fell(boost_output_a_out));
endmodule

// ---- bench/sps_step_ctl.sv ----
// step and direction controller model for the sequencer inputs
`timescale 1ns/1ps
module sps_step_ctl (
  input  wire logic clock_in,             // clock
  output logic      step_strobe_out,      // step strobe, idles high
  output logic      rotation_sense_out,   // high forward
  output logic      half_step_select_out  // low half-step
);
  // idle at the level an open input reads as
  initial begin
    step_strobe_out      = 1'b1;
    rotation_sense_out   = 1'b1;
    half_step_select_out = 1'b1;
  end
  // settle sense and mode while high, fall, hold low, rise and flip sense
  task automatic step(input logic fwd, input logic half, input int low_cyc);
    @(posedge clock_in);
    rotation_sense_out   <= fwd;
    half_step_select_out <= ~half;
    @(posedge clock_in);
    step_strobe_out <= 1'b0;
    repeat (low_cyc) @(posedge clock_in);
    step_strobe_out    <= 1'b1;
    rotation_sense_out <= ~fwd;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench of the stepper phase sequencer
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned BC = 20; // shortened boost on-time
  logic        clock_in, resetn_in, kill, wr, rd, strobe, sense, hsel;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  drv;
  logic [1:0]  zro, bst;
  logic [2:0]  pos;
  int          n_errors, compares;
  sps_phase_sequencer #(.BOOST_CYCLES(BC), .PWRUP_CYCLES(4)) u_dut (
    .clock_in(clock_in), .resetn_in(resetn_in), .step_strobe_in(strobe),
    .rotation_sense_in(sense), .half_step_select_in(hsel), .output_kill_in(kill),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .winding_a_drive_1_out(drv[3]), .winding_a_drive_2_out(drv[2]),
    .winding_b_drive_1_out(drv[1]), .winding_b_drive_2_out(drv[0]),
    .zero_current_a_out(zro[1]), .zero_current_b_out(zro[0]),
    .boost_output_a_out(bst[1]), .boost_output_b_out(bst[0]));
  sps_step_ctl u_ctl (.clock_in(clock_in), .step_strobe_out(strobe),
    .rotation_sense_out(sense), .half_step_select_out(hsel));
  // clock of 20 ns period
  always #10 clock_in = ~clock_in;
  // compare and count
  task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t ns: %s", $time, m);
    end
  endtask
  // register write, one strobe cycle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  // register read, data taken in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // drives and zero flags {a1, a2, b1, b2, zero a, zero b} of a position
  function automatic logic [5:0] expect_out(input logic [2:0] p);
    logic a1, a2, b1, b2;
    a1 = (p == 3'h7 || p <= 3'h1);
    b1 = (p >= 3'h1 && p <= 3'h3);
    a2 = (p >= 3'h3 && p <= 3'h5);
    b2 = (p >= 3'h5);
    return {a1, a2, b1, b2, ~(a1 | a2), ~(b1 | b2)};
  endfunction
  // one step, then the expected position and outputs
  task automatic do_step(input logic f, input logic h);
    logic [5:0] e;
    logic [5:0] o;
    logic [1:0] b;
    logic [2:0] d;
    u_ctl.step(f, h, 1);
    o   = expect_out(pos);
    d   = (h || !pos[0]) ? 3'h1 : 3'h2;
    pos = f ? pos + d : pos - d;
    e   = expect_out(pos);
    b   = {o[5:4] != e[5:4], o[3:2] != e[3:2]};
    if (kill) begin
      e[5:2] = 4'h0;
      b      = 2'h0;
    end
    #1 check({26'h0, drv, zro}, {26'h0, e}, "drive pattern after step");
    check({30'h0, bst & b}, {30'h0, b}, "boost missing after phase change");
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock_in);
    n_errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    close_out();
  end
  // -------------------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------------------
  initial begin
    clock_in  = 1'b0;
    resetn_in = 1'b0;
    kill      = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = 8'h00;
    wdata     = 32'h0;
    got       = 32'h0;
    pos       = 3'h1;
    n_errors  = 0;
    compares  = 0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    u_ctl.step(1'b1, 1'b1, 1);
    #1 check({28'h0, drv}, 32'h0, "drives on during power-up hold");
    for (int i = 0; i < 20 && got[13] !== 1'b1; i++) rd_reg(8'h08, got);
    rd_reg(8'h08, got);
    check(got & 32'hfffff3ff, 32'h20a1, "status after power-up");
    rd_reg(8'h00, got);
    check(got, 32'h2, "control reset value");
    rd_reg(8'h04, got);
    check(got, 32'(BC), "boost count reset value");
    rd_reg(8'h0c, got);
    check(got, 32'h0, "step taken during hold");
    rd_reg(8'h10, got);
    check(got, 32'h0, "unmapped read");
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 5; k++) begin
        do_step(m[1], ~m[0]);
        repeat (BC + 4) @(posedge clock_in);
        #1 check({30'h0, bst}, 32'h0, "boost on past its on-time");
      end
    end
    do_step(1'b1, 1'b0);
    do_step(1'b1, 1'b0);
    repeat (BC + 4) @(posedge clock_in);
    rd_reg(8'h0c, got);
    check(got, 32'd22, "step count");
    $display("test stepping done");
    @(posedge clock_in);
    kill <= 1'b1;
    do_step(1'b0, 1'b1);
    rd_reg(8'h08, got);
    check(got & 32'h1007, 32'h1000 | 32'(pos), "status under kill");
    @(posedge clock_in);
    kill <= 1'b0;
    repeat (2) @(posedge clock_in);
    #1 check({26'h0, drv, zro}, {26'h0, expect_out(pos)}, "drives after kill");
    wr_reg(8'h00, 32'h3);
    rd_reg(8'h00, got);
    check(got, 32'h3, "control write");
    check({28'h0, drv}, 32'h0, "drives under soft kill");
    wr_reg(8'h00, 32'h2);
    repeat (BC + 4) @(posedge clock_in);
    do_step(1'b1, 1'b1);
    $display("test kill done");
    close_out();
  end
endmodule
bind sps_phase_sequencer sps_chk #(.BOOST_CYCLES(BOOST_CYCLES), .ADDR_W(ADDR_W)) u_chk (
  .clock_in(clock_in), .resetn_in(resetn_in), .step_strobe_in(step_strobe_in),
  .output_kill_in(output_kill_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .winding_a_drive_1_out(winding_a_drive_1_out), .winding_a_drive_2_out(winding_a_drive_2_out),
  .winding_b_drive_1_out(winding_b_drive_1_out), .winding_b_drive_2_out(winding_b_drive_2_out),
  .zero_current_a_out(zero_current_a_out), .zero_current_b_out(zero_current_b_out),
  .boost_output_a_out(boost_output_a_out), .boost_output_b_out(boost_output_b_out));
